// ==== epl_params.svh ====
`ifndef EPL_PARAMS_SVH
`define EPL_PARAMS_SVH

// ****************************************************************
// Protocol byte codes
// ****************************************************************
`define EPL_SYNC_BYTE     8'hFF
`define EPL_DATA_CODE     8'h03
`define EPL_CANCEL_CODE   8'h18
`define EPL_RESTART_CODE  8'h05
`define EPL_ACK_BYTE      8'h06
`define EPL_NAK_BYTE      8'h15

// ****************************************************************
// Frame sizes
// ****************************************************************
`define EPL_COORD_BYTES   12
`define EPL_FUNC_BYTES    2
`define EPL_GREET_BYTES   16
`define EPL_DATA_BYTES    16

// ****************************************************************
// Timing
// ****************************************************************
`define EPL_CLK_HZ        40000000
`define EPL_BAUD          9600
`define EPL_BIT_CYCLES    (`EPL_CLK_HZ / `EPL_BAUD)
`define EPL_MOVE_US       19760
`define EPL_MOVE_CYCLES   (`EPL_MOVE_US * 40)

`endif

// ==== epl_pkg.sv ====
package epl_pkg;

  // ****************************************************************
  // Main sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    EPL_IDLE,
    EPL_CHECK,
    EPL_GREET,
    EPL_WAIT,
    EPL_DATA,
    EPL_REPLY,
    EPL_FLUSH,
    EPL_WARN,
    EPL_FATAL
  } epl_state_t;

  // ****************************************************************
  // Byte transmitter states
  // ****************************************************************
  typedef enum logic [1:0] {
    EPL_TX_IDLE,
    EPL_TX_SHIFT
  } epl_tx_state_t;

endpackage

// ==== epl_stream_if.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Byte stream between receiver, buffer and sequencer
// ****************************************************************
interface epl_stream_if #(parameter int W = 8);
  logic         valid;  // Byte present
  logic         ready;  // Sink accepts
  logic [W-1:0] data;   // Byte value
  logic         flush;  // Drop buffered bytes

  modport src (output valid, output data, input ready, input flush);
  modport snk (input valid, input data, output ready, output flush);
endinterface

// ==== epl_fifo.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Small flip-flop FIFO
// ****************************************************************
module epl_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  epl_stream_if.snk in_s,
  epl_stream_if.src out_s
);

  localparam int AW = $clog2(D);

  // Whole state in one struct
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } epl_fifo_st_t;

  epl_fifo_st_t s_q;  // Registered state
  epl_fifo_st_t s_d;  // Next state
  logic         push; // Write this cycle
  logic         pop;  // Read this cycle

  // Honest full and empty flags
  assign in_s.ready  = (s_q.cnt != (AW+1)'(D));
  assign out_s.valid = (s_q.cnt != '0);
  assign out_s.data  = s_q.mem[s_q.rp];
  assign in_s.flush  = out_s.flush;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    if (out_s.flush) begin
      // Flush empties the buffer
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wp] = in_s.data;
        s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
        s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== epl_uart_rx.sv ====
`timescale 1ns/10ps
`include "epl_params.svh"

// ****************************************************************
// Asynchronous serial byte receiver, 8N1
// ****************************************************************
module epl_uart_rx #(
  parameter int BIT_CYCLES = `EPL_BIT_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic rxd,
  epl_stream_if.src out_s,
  output logic      overrun
);

  // Whole state in one struct
  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        vld;
    logic [7:0]  dat;
    logic        ovr;
  } epl_rx_st_t;

  epl_rx_st_t s_q;  // Registered state
  epl_rx_st_t s_d;  // Next state

  assign out_s.valid = s_q.vld;
  assign out_s.data  = s_q.dat;
  assign overrun     = s_q.ovr;

  // ****************************************************************
  // Bit sampling at mid-cell
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ovr = 1'b0;
    if (s_q.vld && out_s.ready) begin
      s_d.vld = 1'b0;
    end
    if (!s_q.busy) begin
      // Wait for start edge
      if (!rxd) begin
        s_d.busy = 1'b1;
        s_d.cnt  = 16'(BIT_CYCLES / 2);
        s_d.bitn = '0;
      end
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end else begin
      s_d.cnt  = 16'(BIT_CYCLES - 1);
      s_d.bitn = s_q.bitn + 1'b1;
      if (s_q.bitn == 4'h0 && rxd) begin
        s_d.busy = 1'b0;  // False start
      end else if (s_q.bitn >= 4'h1 && s_q.bitn <= 4'h8) begin
        s_d.sh = {rxd, s_q.sh[7:1]};
      end else if (s_q.bitn == 4'h9) begin
        // Stop bit: hand byte on
        s_d.busy = 1'b0;
        if (s_d.vld) begin
          s_d.ovr = 1'b1;
        end else begin
          s_d.vld = 1'b1;
          s_d.dat = s_q.sh;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== epl_link.sv ====
`timescale 1ns/10ps
`include "epl_params.svh"
// Summary of operation
// RQ1: Check board fitted; else board-missing warning
// RQ2: Assert DTR; CTS low means partner absent
// RQ3: Greet: FF FF 03, coordinates, checksum
// RQ4: Partner data: 03, two function, twelve coords
// RQ5: Cancel 18: send ACK, end mode
// RQ6: Restart 05: resend coordinates, then wait
// RQ7: Valid data: ACK, then move 19.76 ms
// RQ8: Keep receiving while motion runs
// RQ9: Bad command: NAK and clear buffer
// RQ10: Partner resends after NAK, one outstanding
// RQ11: Checksum is XOR of bytes from zero
// RQ12: Cancel and restart carry no checksum
// RQ13: Step rate limits raise rate warnings
// RQ14: Joint limit: withhold command, warn
// RQ15: Interrupt button raises interrupt warning
// RQ16: Hold: finish output, suspend until clear
// RQ17: Transmitter fault raises warning
// RQ18: Run function when coordinates are reached
// RQ19: Warning; cancel ends link, enter restarts
// RQ20: Partner sends coordinates near 50 Hz
// RQ21: Link runs at 9600 baud or faster
// RQ22: Bad checksum or code: answer NAK
module epl_link #(
  parameter int BIT_CYCLES  = `EPL_BIT_CYCLES,
  parameter int MOVE_CYCLES = `EPL_MOVE_CYCLES,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         mode_start,
  input  wire logic         board_present,
  input  wire logic         cts,
  input  wire logic         rxd,
  input  wire logic [95:0]  present_coords,
  input  wire logic         tx_fault,
  input  wire logic         interrupt_button,
  input  wire logic         hold_req,
  input  wire logic         trans_over,
  input  wire logic         orient_over,
  input  wire logic         joint_over,
  input  wire logic         operator_cancel,
  input  wire logic         operator_enter,
  output logic              txd,
  output logic              dtr,
  output logic              external_path_mode,
  output logic              move_start,
  output logic [95:0]       move_target,
  output logic              func_exec,
  output logic [15:0]       func_code,
  output logic              board_missing_warning,
  output logic              partner_absent_warning,
  output logic              interrupt_warning,
  output logic              translation_rate_warning,
  output logic              orientation_rate_warning,
  output logic              transmitter_fault_warning,
  output logic              joint_limit_warning,
  output logic              terminal_link_error,
  output logic              next_point
);
  epl_stream_if #(.W(8)) rx_s ();   // Receiver to buffer
  epl_stream_if #(.W(8)) cmd_s ();  // Buffer to sequencer
  logic rx_ovr;                     // Receiver overrun
  epl_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rxd      (rxd),
    .out_s    (rx_s),
    .overrun  (rx_ovr)
  );
  epl_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .in_s     (rx_s),
    .out_s    (cmd_s)
  );
  // Whole state in one struct
  typedef struct packed {
    epl_pkg::epl_state_t    st;
    epl_pkg::epl_tx_state_t txs;
    logic [4:0]   idx;      // Frame byte index
    logic [7:0]   csum;     // Running checksum
    logic [127:0] rxbuf;    // Data command bytes
    logic [7:0]   reply;    // ACK or NAK
    logic         finish;   // Leave after reply
    logic [7:0]   txsh;     // Transmit shifter
    logic [3:0]   txbit;    // Transmit bit count
    logic [15:0]  txcnt;    // Baud divider
    logic         txd;
    logic         dtr;
    logic         mode;
    logic         mv_start;
    logic [95:0]  tgt;
    logic [31:0]  mvcnt;    // Motion time left
    logic         pend;     // Function pending
    logic [15:0]  fpend;
    logic         fexec;
    logic [15:0]  fcode;
    logic [7:0]   warn;     // Warning flags
    logic         lnkerr;
    logic         nxt;
  } epl_st_t;
  epl_st_t s_q;         // Registered state
  epl_st_t s_d;         // Next state
  logic    tx_busy;     // Transmitter occupied
  logic    warn_any;    // Any fault warning
  logic [7:0] gbyte;    // Greeting byte
  assign tx_busy  = (s_q.txs != epl_pkg::EPL_TX_IDLE);
  assign warn_any = |s_q.warn;
  // Greeting byte select: FF FF 03 coords checksum [RQ3]
  always_comb begin
    if (s_q.idx < 5'h02) begin
      gbyte = `EPL_SYNC_BYTE;
    end else if (s_q.idx == 5'h02) begin
      gbyte = `EPL_DATA_CODE;
    end else if (s_q.idx < 5'h0F) begin
      gbyte = present_coords[8*(s_q.idx-5'h03) +: 8];
    end else begin
      gbyte = s_q.csum;
    end
  end
  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.mv_start = 1'b0;
    s_d.fexec    = 1'b0;
    s_d.nxt      = 1'b0;
    cmd_s.ready  = 1'b0;
    cmd_s.flush  = 1'b0;
    // Byte transmitter, 8N1 at link rate [RQ21]
    if (tx_busy) begin
      if (s_q.txcnt != '0) begin
        s_d.txcnt = s_q.txcnt - 1'b1;
      end else begin
        s_d.txcnt = 16'(BIT_CYCLES - 1);
        s_d.txbit = s_q.txbit + 1'b1;
        if (s_q.txbit == 4'h0) begin
          s_d.txd = 1'b0;
        end else if (s_q.txbit <= 4'h8) begin
          s_d.txd  = s_q.txsh[0];
          s_d.txsh = {1'b0, s_q.txsh[7:1]};
        end else if (s_q.txbit == 4'h9) begin
          s_d.txd = 1'b1;
        end else begin
          s_d.txs = epl_pkg::EPL_TX_IDLE;
        end
      end
    end
    // Motion timer; function runs on arrival [RQ7] [RQ18]
    if (s_q.mvcnt != '0 && !hold_req) begin
      s_d.mvcnt = s_q.mvcnt - 1'b1;
      if (s_q.mvcnt == 32'h1 && s_q.pend) begin
        s_d.fexec = 1'b1;
        s_d.fcode = s_q.fpend;
        s_d.pend  = 1'b0;
      end
    end
    // Warnings while the mode runs
    if (s_q.mode) begin
      if (s_q.st != epl_pkg::EPL_CHECK && !cts) begin
        s_d.warn[1] = 1'b1;  // [RQ2]
      end
      if (interrupt_button) begin
        s_d.warn[2] = 1'b1;  // [RQ15]
      end
      if (tx_fault) begin
        s_d.warn[5] = 1'b1;  // [RQ17]
      end
    end
    unique case (s_q.st)
      epl_pkg::EPL_IDLE: begin
        if (mode_start) begin
          s_d.st   = epl_pkg::EPL_CHECK;
          s_d.mode = 1'b1;
          s_d.dtr  = 1'b1;  // [RQ2]
        end
      end
      epl_pkg::EPL_CHECK: begin
        cmd_s.flush = 1'b1;
        if (!board_present) begin
          s_d.warn[0] = 1'b1;  // [RQ1]
        end else if (!cts) begin
          s_d.warn[1] = 1'b1;  // [RQ2]
        end else begin
          s_d.st   = epl_pkg::EPL_GREET;
          s_d.idx  = '0;
          s_d.csum = '0;
        end
      end
      epl_pkg::EPL_GREET: begin
        // Send sixteen bytes [RQ3] [RQ6]
        if (!tx_busy && s_d.txs == epl_pkg::EPL_TX_IDLE) begin
          s_d.txs   = epl_pkg::EPL_TX_SHIFT;
          s_d.txsh  = gbyte;
          s_d.txbit = '0;
          s_d.txcnt = '0;
          if (s_q.idx >= 5'h02) begin
            s_d.csum = s_q.csum ^ gbyte;  // [RQ11]
          end
          s_d.idx = s_q.idx + 1'b1;
          if (s_q.idx == 5'(`EPL_GREET_BYTES - 1)) begin
            s_d.st = epl_pkg::EPL_WAIT;
          end
        end
      end
      epl_pkg::EPL_WAIT: begin
        // Accept while moving [RQ8]
        cmd_s.ready = cmd_s.valid;
        s_d.idx  = '0;
        s_d.csum = '0;
        if (cmd_s.valid) begin
          if (cmd_s.data == `EPL_CANCEL_CODE) begin
            s_d.reply  = `EPL_ACK_BYTE;  // [RQ5] [RQ12]
            s_d.finish = 1'b1;
            s_d.st     = epl_pkg::EPL_REPLY;
          end else if (cmd_s.data == `EPL_RESTART_CODE) begin
            s_d.st = epl_pkg::EPL_GREET;  // [RQ6] [RQ12]
          end else if (cmd_s.data == `EPL_DATA_CODE) begin
            s_d.st   = epl_pkg::EPL_DATA;  // [RQ4]
            s_d.csum = cmd_s.data;
            s_d.idx  = 5'h01;
          end else begin
            s_d.reply = `EPL_NAK_BYTE;  // [RQ22]
            s_d.st    = epl_pkg::EPL_FLUSH;
          end
        end
      end
      epl_pkg::EPL_DATA: begin
        cmd_s.ready = cmd_s.valid;
        if (cmd_s.valid) begin
          s_d.rxbuf[8*s_q.idx +: 8] = cmd_s.data;
          s_d.csum = s_q.csum ^ cmd_s.data;  // [RQ11]
          s_d.idx  = s_q.idx + 1'b1;
          if (s_q.idx == 5'(`EPL_DATA_BYTES - 1)) begin
            if (s_q.csum != cmd_s.data) begin
              s_d.reply = `EPL_NAK_BYTE;  // [RQ22]
              s_d.st    = epl_pkg::EPL_FLUSH;
            end else begin
              s_d.reply = `EPL_ACK_BYTE;  // [RQ7]
              s_d.st    = epl_pkg::EPL_REPLY;
            end
          end
        end
      end
      epl_pkg::EPL_FLUSH: begin
        cmd_s.flush = 1'b1;  // [RQ9]
        s_d.st      = epl_pkg::EPL_REPLY;
      end
      epl_pkg::EPL_REPLY: begin
        // Hold: finish current output first [RQ16]
        if (!tx_busy && !hold_req) begin
          s_d.txs   = epl_pkg::EPL_TX_SHIFT;
          s_d.txsh  = s_q.reply;
          s_d.txbit = '0;
          s_d.txcnt = '0;
          s_d.st    = epl_pkg::EPL_WAIT;
          if (s_q.finish) begin
            s_d.finish = 1'b0;
            s_d.mode   = 1'b0;  // [RQ5]
            s_d.dtr    = 1'b0;
            s_d.nxt    = 1'b1;
            s_d.st     = epl_pkg::EPL_IDLE;
          end else if (s_q.reply == `EPL_ACK_BYTE) begin
            if (joint_over) begin
              s_d.warn[6] = 1'b1;  // [RQ14]
            end else begin
              s_d.mv_start = 1'b1;  // [RQ7]
              s_d.tgt      = s_q.rxbuf[119:24];
              s_d.mvcnt    = 32'(MOVE_CYCLES);
              s_d.pend     = 1'b1;  // [RQ18]
              s_d.fpend    = s_q.rxbuf[23:8];
            end
            s_d.warn[3] = s_q.warn[3] | trans_over;   // [RQ13]
            s_d.warn[4] = s_q.warn[4] | orient_over;  // [RQ13]
          end
        end
      end
      epl_pkg::EPL_WARN: begin
        // Operator answer to warning [RQ19]
        if (operator_cancel) begin
          s_d.lnkerr = 1'b1;
          s_d.st     = epl_pkg::EPL_FATAL;
        end else if (operator_enter) begin
          s_d.warn = s_d.warn & ~s_q.warn;  // Fresh events survive
          s_d.st   = epl_pkg::EPL_CHECK;
        end
      end
      epl_pkg::EPL_FATAL: begin
        // Cancel of link error leaves mode
        if (operator_cancel) begin
          s_d.lnkerr = 1'b0;
          s_d.warn   = '0;
          s_d.mode   = 1'b0;
          s_d.dtr    = 1'b0;
          s_d.st     = epl_pkg::EPL_IDLE;
        end
      end
    endcase
    // Any warning stops the link [RQ19]
    if (s_q.mode && warn_any && s_q.st != epl_pkg::EPL_WARN
        && s_q.st != epl_pkg::EPL_FATAL) begin
      s_d.st = epl_pkg::EPL_WARN;
      s_d.mvcnt = '0;
      cmd_s.flush = 1'b1;
    end
    if (rx_ovr && s_q.st == epl_pkg::EPL_DATA) begin
      s_d.reply = `EPL_NAK_BYTE;  // [RQ9]
      s_d.st    = epl_pkg::EPL_FLUSH;
    end
  end
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // Outputs straight from flip-flops
  assign txd                       = s_q.txd;
  assign dtr                       = s_q.dtr;
  assign external_path_mode        = s_q.mode;
  assign move_start                = s_q.mv_start;
  assign move_target               = s_q.tgt;
  assign func_exec                 = s_q.fexec;
  assign func_code                 = s_q.fcode;
  assign board_missing_warning     = s_q.warn[0];
  assign partner_absent_warning    = s_q.warn[1];
  assign interrupt_warning         = s_q.warn[2];
  assign translation_rate_warning  = s_q.warn[3];
  assign orientation_rate_warning  = s_q.warn[4];
  assign transmitter_fault_warning = s_q.warn[5];
  assign joint_limit_warning       = s_q.warn[6];
  assign terminal_link_error       = s_q.lnkerr;
  assign next_point                = s_q.nxt;
endmodule

// ==== epl_link_asserts.sv ====
`timescale 1ns/10ps

// ********************************
// Port checker for the path link
// ********************************
module epl_link_asserts #(
  parameter int MOVE_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic board_present,
  input wire logic cts,
  input wire logic tx_fault,
  input wire logic interrupt_button,
  input wire logic hold_req,
  input wire logic operator_cancel,
  input wire logic operator_enter,
  input wire logic dtr,
  input wire logic external_path_mode,
  input wire logic move_start,
  input wire logic func_exec,
  input wire logic board_missing_warning,
  input wire logic partner_absent_warning,
  input wire logic interrupt_warning,
  input wire logic transmitter_fault_warning,
  input wire logic joint_limit_warning,
  input wire logic terminal_link_error,
  input wire logic next_point
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] mv_q;  // Unpaused cycles since move start
  logic        any_w; // Some warning up, rate warnings not included
  assign any_w = board_missing_warning | partner_absent_warning
               | interrupt_warning | transmitter_fault_warning
               | joint_limit_warning;
  // Motion timer model, frozen by hold
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mv_q <= 32'h00000000;
    else if (move_start) mv_q <= 32'h00000000;
    else if (!hold_req && mv_q != 32'hFFFFFFFF)
      mv_q <= mv_q + 32'h00000001;
  end
  chk_dtr_in_mode:
    assert property (external_path_mode |-> dtr) else $error("dtr low");
  chk_cts_loss:
    assert property (external_path_mode && !cts |-> ##[0:4]
      partner_absent_warning) else $error("cts loss not flagged");
  chk_board_cause:
    assert property ($rose(board_missing_warning) |-> !$past(board_present))
    else $error("board warning with board fitted");
  chk_button_warn:
    assert property (external_path_mode && interrupt_button |-> ##[0:4]
      interrupt_warning) else $error("button not flagged");
  chk_txfault_warn:
    assert property (external_path_mode && tx_fault |-> ##[0:4]
      transmitter_fault_warning) else $error("tx fault not flagged");
  chk_joint_no_move:
    assert property (joint_limit_warning |-> !move_start)
    else $error("move despite joint limit");
  chk_func_timing:
    assert property (func_exec |-> mv_q >= MOVE_CYCLES - 2
      && mv_q <= MOVE_CYCLES) else $error("function off move end");
  chk_warn_sticky:
    assert property (interrupt_warning && !operator_enter && !operator_cancel
      |=> interrupt_warning) else $error("warning dropped early");
  chk_clear_cause:
    assert property ($fell(joint_limit_warning) |-> $past(operator_enter
      | operator_cancel)) else $error("warning cleared unasked");
  chk_cancel_fatal:
    assert property (operator_cancel && any_w |-> ##[1:4]
      terminal_link_error) else $error("no link error on cancel");
  cov_move: cover property (move_start);
  cov_func: cover property (func_exec);
  cov_next: cover property (next_point);
  cov_fatal: cover property ($rose(terminal_link_error));
endmodule

bind epl_link epl_link_asserts #(.MOVE_CYCLES(MOVE_CYCLES)) chk_u (.*);

// ==== epl_host_model.sv ====
`timescale 1ns/10ps

// ********************************
// External computer on the link
// ********************************
module epl_host_model #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic core_clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts
);
  logic [7:0] got_q[$]; // Bytes seen on txd
  logic [7:0] sh;       // Receive shift
  logic       present;  // Partner attached
  assign cts = present;
  initial begin
    rxd = 1'b1;
    present = 1'b1;
  end
  // One 8N1 byte, low bit first, idle high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = fr[i];
      repeat (BIT_CYCLES) @(posedge core_clk);
      #2;
    end
  endtask
  // Code, function, coordinates, XOR sum
  task automatic send_data(input logic [15:0] fn, input logic [95:0] c,
                           input logic bad);
    logic [119:0] body;
    logic [7:0]   s;
    body = {c, fn, 8'h03};
    s = 8'h00;
    for (int i = 0; i < 15; i++) begin
      s ^= body[8*i+:8];
      send_byte(body[8*i+:8]);
    end
    send_byte(s ^ {7'h00, bad});
  endtask
  // Sample each txd bit mid-cell
  always begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge core_clk);
      sh[i] = txd;
    end
    repeat (BIT_CYCLES) @(posedge core_clk);
    got_q.push_back(sh);
  end
endmodule

// ==== tb_external_path_serial_link.sv ====
`timescale 1ns/10ps

// ********************************
// Bench for the path link
// ********************************
module tb_external_path_serial_link;
  localparam int BC = 8;  // Short bit time
  localparam int MC = 50; // Short move time
  logic        core_clk, rst_n, mode_start, board_present, tx_fault;
  logic        cts, rxd, interrupt_button, hold_req, trans_over;
  logic        orient_over, joint_over, operator_cancel, operator_enter;
  logic        txd, dtr, external_path_mode, move_start, func_exec;
  logic        board_missing_warning, partner_absent_warning, next_point;
  logic        interrupt_warning, translation_rate_warning;
  logic        orientation_rate_warning, transmitter_fault_warning;
  logic        joint_limit_warning, terminal_link_error;
  logic [95:0] present_coords, move_target, tgt;
  logic [15:0] func_code, fcode;
  logic [31:0] seed;
  logic [5:0]  src, warn;
  int          err_total, n_compared, n_moves, n_next, k;
  assign {tx_fault, interrupt_button, orient_over} = src[4:2];
  assign {trans_over, joint_over} = src[1:0];
  assign warn = {partner_absent_warning, transmitter_fault_warning,
                 interrupt_warning, orientation_rate_warning,
                 translation_rate_warning, joint_limit_warning};
  epl_link #(.BIT_CYCLES(BC), .MOVE_CYCLES(MC)) dut_u (.*);
  epl_host_model #(.BIT_CYCLES(BC)) host_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Capture motion, function and exit pulses
  always @(posedge core_clk) begin
    if (move_start === 1'b1) begin
      n_moves++;
      tgt = move_target;
    end
    if (func_exec === 1'b1) fcode = func_code;
    if (next_point === 1'b1) n_next++;
  end
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random coordinates and function word
  task automatic rnd(output logic [95:0] v, output logic [15:0] f);
    for (int i = 0; i < 3; i++) begin
      repeat (9) seed = lfsr(seed);
      v[32*i+:32] = seed;
    end
    f = seed[27:12];
  endtask
  // Next byte from the link, bounded wait
  task automatic rx(input logic [7:0] e);
    logic [7:0] got;
    for (int w = 0; w < 3000 && host_u.got_q.size() == 0; w++) tick(1);
    got = 8'hXX;
    if (host_u.got_q.size() > 0) got = host_u.got_q.pop_front();
    check(got, e);
  endtask
  task automatic greet();
    logic [7:0] s;
    s = 8'h03;
    rx(8'hFF);
    rx(8'hFF);
    rx(8'h03);
    for (int i = 0; i < 12; i++) begin
      rx(present_coords[8*i+:8]);
      s ^= present_coords[8*i+:8];
    end
    rx(s);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    logic [95:0] c;
    logic [15:0] f, pf;
    int          m;
    seed = 32'hDA7F98EE;
    src = 6'h00;
    {mode_start, hold_req, operator_cancel, operator_enter} = 4'h0;
    board_present = 1'b0;
    rst_n = 1'b0;
    rnd(present_coords, f);
    tick(12);
    rst_n = 1'b1;
    // Missing board, operator cancels
    pulse(mode_start);
    tick(10);
    check(board_missing_warning, 1);
    pulse(operator_cancel);
    tick(5);
    check(terminal_link_error, 1);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    board_present = 1'b1;
    pulse(mode_start);
    greet();
    check(dtr, 1);
    // Commands sent one at a time, each after the last move has ended
    for (k = 0; k < 4; k++) begin
      m = n_moves;
      pf = f;
      rnd(c, f);
      host_u.send_data(f, c, 1'b0);
      if (k > 0) check(fcode, pf);
      rx(8'h06);
      tick(BC);
      check(n_moves, m + 1);
      check(tgt, c);
    end
    host_u.send_data(f, c, 1'b1);
    rx(8'h15);
    host_u.send_data(f, c, 1'b0);
    rx(8'h06);
    host_u.send_byte(8'h41);
    rx(8'h15);
    // Hold stalls the reply
    hold_req = 1'b1;
    host_u.send_data(f, c, 1'b0);
    tick(200);
    check(host_u.got_q.size(), 0);
    hold_req = 1'b0;
    rx(8'h06);
    host_u.send_byte(8'h05);
    greet();
    // Six warning sources (all but missing board), operator enter
    for (k = 0; k < 6; k++) begin
      m = n_moves;
      src = 6'h01 << k;
      host_u.present = !src[5];
      rnd(c, f);
      if (k < 3) host_u.send_data(f, c, 1'b0);
      tick(400);
      check(warn[k], 1);
      if (k == 0) check(n_moves, m);
      src = 6'h00;
      host_u.present = 1'b1;
      tick(2);
      host_u.got_q.delete();
      pulse(operator_enter);
      greet();
    end
    host_u.send_byte(8'h18);
    rx(8'h06);
    tick(BC + 4);
    check(external_path_mode, 0);
    check(n_next, 1);
    print_verdict();
  end
endmodule
